// *** adc_defs.svh ***
// Purpose: Offsets, field positions, reset values and timing counts of the dual converter control block
// Assumes: 25 MHz ref_clk, 32-bit AHB-Lite register bus
// Notes: Definitions only
`ifndef ADC_DEFS_SVH
`define ADC_DEFS_SVH

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_DATA_A 8'h08
`define ADDR_DATA_B 8'h0C

// ----------------------------------------
// Control fields and reset value
// ----------------------------------------
`define CTRL_PD_A 0
`define CTRL_PD_B 1
`define CTRL_STAB 2
`define CTRL_FMT 3
`define CTRL_RESET 4'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 40
`define WORD_WIDTH 14
`define LATENCY 7
`define DLL_SETTLE_NS 3000
`define DLL_SETTLE_CYC ((`DLL_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REF_WAKE_MS 5
`define REF_WAKE_CYC ((`REF_WAKE_MS * 1000000) / `CLK_PERIOD_NS)
`define PERIOD_WIDTH 16

`endif

// *** adc_pkg.sv ***
// Purpose: Types shared by the dual converter control block
// Assumes: adc_defs.svh supplies widths
// Notes: Holds carriers and the output format function
`default_nettype none
`include "adc_defs.svh"

package adc_pkg;

	// One converted word with its validity
	typedef struct packed {
		logic valid;
		logic [`WORD_WIDTH-1:0] word;
	} sample_t;

	// Software control bits
	typedef struct packed {
		logic fmt_twos;
		logic stab_en;
		logic pd_b;
		logic pd_a;
	} ctrl_t;

	// Offset binary to two's complement is a flip of the top bit
	function automatic logic [`WORD_WIDTH-1:0] fmt_word(input logic [`WORD_WIDTH-1:0] raw, input logic twos);
		fmt_word = {raw[`WORD_WIDTH-1] ^ twos, raw[`WORD_WIDTH-2:0]};
	endfunction : fmt_word

endpackage : adc_pkg
`default_nettype wire

// *** adc_channel.sv ***
// Purpose: One converter channel: sample edge, duty regeneration, settle window, seven-deep pipeline
// Assumes: sample_clk and analog_word are synchronous to ref_clk
// Notes: Output sample is latched on the sample rising edge
`timescale 1ns/1ns
`default_nettype none
`include "adc_defs.svh"

module adc_channel (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic sample_clk,
	input wire logic [`WORD_WIDTH-1:0] analog_word,
	input wire logic powerdown,
	input wire logic stab_en,
	input wire logic fmt_twos,
	input wire logic refs_ready,
	output adc_pkg::sample_t out_sample,
	output logic int_clk,
	output logic settling
);
	import adc_pkg::*;

	// ----------------------------------------
	// Edge and period measurement
	// ----------------------------------------
	logic clk_d;
	logic [`PERIOD_WIDTH-1:0] cnt;
	logic [`PERIOD_WIDTH-1:0] period;
	logic [`PERIOD_WIDTH-1:0] settle_cnt;
	sample_t pipe [0:`LATENCY-1];

	wire rise = sample_clk & ~clk_d;
	wire [`PERIOD_WIDTH-1:0] next_cnt = cnt + 16'h0001;
	wire [`PERIOD_WIDTH-1:0] half = period >> 1;
	// Allow one cycle of jitter before calling it a new rate
	wire rate_change = rise && (next_cnt > period + 16'h0001 || period > next_cnt + 16'h0001);
	wire next_settling = settle_cnt != 16'h0000;
	wire [`WORD_WIDTH-1:0] coded = fmt_word(analog_word, fmt_twos);

	// Period between rising edges, counted in ref_clk cycles
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			clk_d <= 1'b0;
			cnt <= 16'h0000;
			period <= 16'h0000;
		end else begin
			clk_d <= sample_clk;
			cnt <= rise ? 16'h0000 : next_cnt;
			if (rise)
				period <= next_cnt;
		end
	end

	// ----------------------------------------
	// Duty regeneration and settle window
	// ----------------------------------------
	// Sampling edge passes through; with the stabilizer the falling edge is remade at half period
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			int_clk <= 1'b0;
			settle_cnt <= 16'h0000;
			settling <= 1'b0;
		end else begin
			if (!stab_en)
				int_clk <= sample_clk;
			else if (rise)
				int_clk <= 1'b1;
			else if (cnt + 16'h0001 >= half)
				int_clk <= 1'b0;
			if (stab_en && rate_change)
				settle_cnt <= 16'(`DLL_SETTLE_CYC);
			else if (!stab_en)
				settle_cnt <= 16'h0000;
			else if (next_settling)
				settle_cnt <= settle_cnt - 16'h0001;
			settling <= next_settling || (stab_en && rate_change);
		end
	end

	// ----------------------------------------
	// Pipeline and output latch
	// ----------------------------------------
	// Standby flushes validity so no stale word is reported after wake-up
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			for (int i = 0; i < `LATENCY; i++)
				pipe[i] <= '0;
			out_sample <= '0;
		end else if (powerdown) begin
			for (int i = 0; i < `LATENCY; i++)
				pipe[i].valid <= 1'b0;
			out_sample.valid <= 1'b0;
		end else if (rise) begin
			// A restarted clock looks like a rate change; only the stabilizer needs to settle on it
			pipe[0] <= '{valid: refs_ready && !next_settling && !(stab_en && rate_change), word: coded};
			for (int i = 1; i < `LATENCY; i++)
				pipe[i] <= pipe[i-1];
			out_sample <= pipe[`LATENCY-1];
		end
	end

endmodule : adc_channel
`default_nettype wire

// *** adc_ctrl.sv ***
// Purpose: Dual converter control with AHB-Lite registers
// Assumes: Sample clocks and words are synchronous to ref_clk; one AHB-Lite master
// Notes: Zero wait state slave; every response OKAY
`timescale 1ns/1ns
`default_nettype none
`include "adc_defs.svh"

module adc_ctrl #(
	parameter int unsigned REF_WAKE_CYCLES = `REF_WAKE_CYC
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic chan_a_clk,
	input wire logic chan_b_clk,
	input wire logic [`WORD_WIDTH-1:0] chan_a_analog,
	input wire logic [`WORD_WIDTH-1:0] chan_b_analog,
	output adc_pkg::sample_t chan_a_data,
	output adc_pkg::sample_t chan_b_data,
	output logic chan_a_int_clk,
	output logic chan_b_int_clk,
	output logic refs_on
);
	import adc_pkg::*;

	// ----------------------------------------
	// Bus address phase capture
	// ----------------------------------------
	ctrl_t ctrl;
	logic wr_pend;
	logic [7:0] wr_addr;
	logic [31:0] wake_cnt;
	logic settle_a;
	logic settle_b;

	wire take = hsel && hready && htrans[1];
	wire [7:0] addr = haddr[7:0];
	wire mapped = haddr[31:8] == 24'h000000;
	wire full_pd = ctrl.pd_a && ctrl.pd_b;
	wire refs_ready = refs_on && wake_cnt == 32'h00000000;
	wire [31:0] status_word = {25'h0000000, settle_b, settle_a, !refs_ready, refs_on,
		chan_b_data.valid, chan_a_data.valid, 1'b0};

	// Read data chosen in the address phase, presented in the data phase
	wire [31:0] next_rdata =
		!mapped ? 32'h00000000 :
		addr == `ADDR_CTRL ? {28'h0000000, ctrl} :
		addr == `ADDR_STATUS ? status_word :
		addr == `ADDR_DATA_A ? {17'h00000, chan_a_data} :
		addr == `ADDR_DATA_B ? {17'h00000, chan_b_data} :
		32'h00000000;

	// Single-cycle answer; write lands in the data phase
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_pend <= take && hwrite && mapped;
			wr_addr <= addr;
			if (take && !hwrite)
				hrdata <= next_rdata;
		end
	end

	// ----------------------------------------
	// Control register
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst)
			ctrl <= `CTRL_RESET;
		else if (wr_pend && wr_addr == `ADDR_CTRL)
			ctrl <= hwdata[3:0];
	end

	// ----------------------------------------
	// Reference power and wake timer
	// ----------------------------------------
	// Partial standby never touches the references, so only full power-down starts the long wait
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			refs_on <= 1'b1;
			wake_cnt <= 32'h00000000;
		end else begin
			refs_on <= !full_pd;
			if (full_pd)
				wake_cnt <= REF_WAKE_CYCLES;
			else if (wake_cnt != 32'h00000000)
				wake_cnt <= wake_cnt - 32'h00000001;
		end
	end

	// ----------------------------------------
	// Channels
	// ----------------------------------------
	adc_channel chan_a (
		.ref_clk(ref_clk),
		.rst(rst),
		.sample_clk(chan_a_clk),
		.analog_word(chan_a_analog),
		.powerdown(ctrl.pd_a),
		.stab_en(ctrl.stab_en),
		.fmt_twos(ctrl.fmt_twos),
		.refs_ready(refs_ready),
		.out_sample(chan_a_data),
		.int_clk(chan_a_int_clk),
		.settling(settle_a)
	);

	adc_channel chan_b (
		.ref_clk(ref_clk),
		.rst(rst),
		.sample_clk(chan_b_clk),
		.analog_word(chan_b_analog),
		.powerdown(ctrl.pd_b),
		.stab_en(ctrl.stab_en),
		.fmt_twos(ctrl.fmt_twos),
		.refs_ready(refs_ready),
		.out_sample(chan_b_data),
		.int_clk(chan_b_int_clk),
		.settling(settle_b)
	);

endmodule : adc_ctrl
`default_nettype wire

// *** adc_ctrl_assertions.sv ***
// Purpose: Port checks of adc_ctrl
// Assumes: hready is tied to hreadyout
// Notes: CTRL is shadowed from bus writes
`timescale 1ns/1ns
`default_nettype none
`include "adc_defs.svh"
module adc_ctrl_chk import adc_pkg::*; #(
	parameter int unsigned REF_WAKE_CYCLES = 50
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic chan_a_clk,
	input wire adc_pkg::sample_t chan_a_data,
	input wire adc_pkg::sample_t chan_b_data,
	input wire logic refs_on
);
	// ----
	// Shadow state
	// ----
	logic wp;
	logic full;
	logic [7:0] wa;
	logic [3:0] sh;
	logic [2:0] ha;
	logic [16:0] wk;
	assign full = &sh[1:0];
	// Wake count is held full in total standby, so it only runs once the references restart
	always_ff @(posedge ref_clk) begin
		wp <= hsel && hready && htrans[1] && hwrite;
		wa <= haddr[7:0];
		if (rst) begin
			sh <= 4'h0;
			ha <= 3'h0;
			wk <= 17'h00000;
		end else begin
			if (wp && wa == `ADDR_CTRL) sh <= hwdata[3:0];
			ha <= {ha[1:0], sh[0]};
			wk <= full ? 17'(REF_WAKE_CYCLES) : wk - 17'(wk != 17'h00000);
		end
	end
	// ----
	// Checks
	// ----
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	resp_okay_a: assert property (!hresp) else $error("bus answer not OKAY");
	ready_up_a: assert property (hreadyout) else $error("bus wait state seen");
	refs_off_a: assert property (full |-> ##[0:2] !refs_on) else $error("refs on in total standby");
	refs_keep_a: assert property (!full && !$past(full) |-> refs_on) else $error("refs dropped");
	pd_a_a: assert property (sh[0] && $past(sh[0]) |-> !chan_a_data.valid) else $error("A valid in standby");
	pd_b_a: assert property (sh[1] && $past(sh[1]) |-> !chan_b_data.valid) else $error("B valid in standby");
	edge_a_a: assert property (!sh[0] && ha == 3'h0 && $changed(chan_a_data) |->
		$past(chan_a_clk) || $past(chan_a_clk, 2)) else $error("A word moved off its edge");
	wake_dead_a: assert property (wk != 17'h00000 |-> !chan_a_data.valid && !chan_b_data.valid)
		else $error("valid during wake");
	cover property (!refs_on);
	cover property ($rose(chan_a_data.valid));
	cover property ($rose(chan_b_data.valid));
endmodule : adc_ctrl_chk
bind adc_ctrl adc_ctrl_chk #(.REF_WAKE_CYCLES(REF_WAKE_CYCLES)) chk (.*);
`default_nettype wire

// *** adc_src.sv ***
// Purpose: Capture-side source of sample clocks and words
// Assumes: hi and lo are 2 or more
// Notes: Words count up once per rising edge
`timescale 1ns/1ns
`default_nettype none
`include "adc_defs.svh"
module adc_src (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic run_a,
	input wire logic run_b,
	input wire logic [3:0] hi,
	input wire logic [3:0] lo,
	output logic clk_a,
	output logic clk_b,
	output logic [13:0] ana_a,
	output logic [13:0] ana_b
);
	// ----
	// Clock source
	// ----
	logic ph;
	logic [3:0] cnt;
	// One phase counter feeds both clocks, so skew is zero; a stopped clock rests low
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			{ph, cnt, clk_a, clk_b} <= 7'h00;
			ana_a <= 14'h0000;
			ana_b <= 14'h2000;
		end else if (cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
		end else begin
			ph <= !ph;
			cnt <= (ph ? lo : hi) - 4'h1;
			clk_a <= !ph && run_a;
			clk_b <= !ph && run_b;
			if (!ph && run_a) ana_a <= ana_a + 14'h0001;
			if (!ph && run_b) ana_b <= ana_b + 14'h0001;
		end
	end
endmodule : adc_src
`default_nettype wire

// *** tb_adc_ctrl.sv ***
// Purpose: Self-checking bench of adc_ctrl
// Assumes: 25 MHz ref_clk, short wake count
// Notes: hsize is fixed at word
`timescale 1ns/1ns
`default_nettype none
`include "adc_defs.svh"
module tb_adc_ctrl;
	import adc_pkg::*;
	localparam int WAKE = 50;
	logic ref_clk = 1'h0, rst = 1'h1, hsel = 1'h0, hwrite = 1'h0, run_a = 1'h1, run_b = 1'h1;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
	logic [3:0] hi = 4'h4, lo = 4'h4;
	logic hreadyout, hresp, ca, cb, ia, ib, refs_on;
	logic [13:0] aa, ab;
	sample_t da, db;
	int n_mismatch = 0, comparisons = 0;
	always #20 ref_clk = !ref_clk;
	adc_src src (.ref_clk(ref_clk), .rst(rst), .run_a(run_a), .run_b(run_b), .hi(hi), .lo(lo),
		.clk_a(ca), .clk_b(cb), .ana_a(aa), .ana_b(ab));
	adc_ctrl #(.REF_WAKE_CYCLES(WAKE)) uut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .chan_a_clk(ca), .chan_b_clk(cb),
		.chan_a_analog(aa), .chan_b_analog(ab), .chan_a_data(da), .chan_b_data(db),
		.chan_a_int_clk(ia), .chan_b_int_clk(ib), .refs_on(refs_on));
	// ----
	// Shared tasks
	// ----
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : end_sim
	// Each phase is held until hready is seen high, so a wait state would be honoured
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h000000, a};
		do @(posedge ref_clk); while (hreadyout !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'h1);
		rd = hrdata;
	endtask : bus
	// Output seen after a sample edge must carry the word taken seven edges earlier
	task automatic lat_chk(input logic f);
		@(posedge cb);
		repeat (3) @(posedge ref_clk);
		chk(db, {1'h1, (ab - 14'h0007) ^ {f, 13'h0000}});
		if (run_a) chk(da, {1'h1, (aa - 14'h0007) ^ {f, 13'h0000}});
	endtask : lat_chk
	// ----
	// Scenarios
	// ----
	task automatic t_regs;
		bus(1'h0, `ADDR_CTRL, 32'h0);
		chk(rd, 32'h0);
		bus(1'h1, `ADDR_CTRL, 32'h8);
		bus(1'h1, 8'h10, 32'hF);
		bus(1'h0, 8'h10, 32'h0);
		chk(rd, 32'h0);
		bus(1'h0, `ADDR_CTRL, 32'h0);
		chk(rd, 32'h8);
	endtask : t_regs
	task automatic t_lat;
		repeat (9) @(posedge cb);
		lat_chk(1'h1);
		bus(1'h1, `ADDR_CTRL, 32'h0);
		repeat (8) @(posedge cb);
		lat_chk(1'h0);
	endtask : t_lat
	task automatic t_pd;
		bus(1'h1, `ADDR_CTRL, 32'h1);
		run_a <= 1'h0;
		repeat (3) @(posedge cb);
		lat_chk(1'h0);
		chk(da.valid, 1'h0);
		chk(refs_on, 1'h1);
		bus(1'h0, `ADDR_STATUS, 32'h0);
		chk(rd & 32'h00000018, 32'h00000008);
		bus(1'h1, `ADDR_CTRL, 32'h0);
		run_a <= 1'h1;
		repeat (8) @(posedge cb);
		lat_chk(1'h0);
	endtask : t_pd
	task automatic t_full;
		bus(1'h1, `ADDR_CTRL, 32'h3);
		run_a <= 1'h0;
		run_b <= 1'h0;
		repeat (20) @(posedge ref_clk);
		chk(refs_on, 1'h0);
		bus(1'h1, `ADDR_CTRL, 32'h0);
		run_a <= 1'h1;
		run_b <= 1'h1;
		bus(1'h0, `ADDR_STATUS, 32'h0);
		chk(rd & 32'h00000010, 32'h00000010);
		repeat (80) @(posedge ref_clk);
		chk({da.valid, db.valid}, 2'h0);
		repeat (8) @(posedge cb);
		lat_chk(1'h0);
	endtask : t_full
	// Uneven input duty, then a rate change while the stabilizer runs
	task automatic t_stab;
		int n;
		n = 0;
		hi <= 4'h6;
		lo <= 4'h2;
		bus(1'h1, `ADDR_CTRL, 32'h4);
		repeat (200) @(posedge ref_clk);
		@(posedge ia);
		@(posedge ref_clk);
		while (ia === 1'h1) begin
			n++;
			chk(ib, 1'h1);
			@(posedge ref_clk);
		end
		chk(n, 4);
		chk(ib, 1'h0);
		hi <= 4'h8;
		lo <= 4'h8;
		// Third edge lies inside the settle window that the new rate opened
		repeat (3) @(posedge cb);
		bus(1'h0, `ADDR_STATUS, 32'h0);
		chk(rd & 32'h00000060, 32'h00000060);
		repeat (7) @(posedge cb);
		repeat (3) @(posedge ref_clk);
		chk(db.valid, 1'h0);
		repeat (20) @(posedge cb);
		lat_chk(1'h0);
	endtask : t_stab
	initial begin
		repeat (6) @(posedge ref_clk);
		rst <= 1'h0;
		@(posedge ref_clk);
		t_regs;
		t_lat;
		t_pd;
		t_full;
		t_stab;
		end_sim;
	end
	// A hang counts against the run
	initial begin
		#400000;
		n_mismatch++;
		end_sim;
	end
endmodule : tb_adc_ctrl
`default_nettype wire
